//--- rtl/dfms_top.sv
// data-flash modify status flags: read-during-modify error, access space latch, done flag
// assumes software on a strobe register port; array reads and interlock writes from the
// flash sequencer arrive as same-clock pulses
//
// Overview of operation
// R1 - array read during program, erase or integrity check sets the error flag
// R2 - error flag sticks until software clear or reset; writing one never sets it
// R3 - space select zero targets main array, one targets shadow/test space
// R4 - space select sampled at first interlock write, held until the next one
// R5 - done reads one after module reset
// R6 - done clears after high-voltage enable rises, and on resume; the code clears it on that rise only with program or erase mode set
// R7 - done sets when a program or erase sequence completes normally
// R8 - high-voltage enable falling aborts operation, done sets within abort latency
// R9 - erase suspend rising suspends erase, done sets within suspend latency
// R10 - done is zero while a high-voltage operation runs, one otherwise
// R11 - software clears error flag by writing one; writing zero leaves it
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dfms_top
   import dfms_pkg::*;
#(
   parameter int SEQ_CYCLES = DFMS_SEQ_CYC,
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // flash sequencer side
   input wire logic array_read,
   input wire logic integrity_check,
   input wire logic first_interlock_write,
   input wire logic seq_complete,
   output logic high_voltage_enable,
   output logic erase_suspend,
   output logic program_mode,
   output logic erase_mode,
   output logic hv_active,
   output logic access_space_select,
   // interrupt
   output logic irq
);

   // ****************************************
   // register decode
   // ****************************************
   dfms_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   wire cfg_wr = req.wr && (req.addr == DFMS_ADDR_CONFIG);
   wire sts_wr = req.wr && (req.addr == DFMS_ADDR_IRQ_STATUS);
   wire msk_wr = req.wr && (req.addr == DFMS_ADDR_IRQ_MASK);

   // ****************************************
   // software control bits
   // ****************************************
   logic hve_reg;
   logic susp_reg;
   logic pgm_reg;
   logic ers_reg;
   logic space_ctl_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         hve_reg <= 1'b0;
         susp_reg <= 1'b0;
         pgm_reg <= 1'b0;
         ers_reg <= 1'b0;
         space_ctl_reg <= DFMS_RST_SPACE;
      end else if (cfg_wr) begin
         hve_reg <= req.wdata[DFMS_BIT_HVE];
         susp_reg <= req.wdata[DFMS_BIT_SUSP];
         pgm_reg <= req.wdata[DFMS_BIT_PGM];
         ers_reg <= req.wdata[DFMS_BIT_ERS];
         space_ctl_reg <= req.wdata[DFMS_BIT_SPACE];
      end
   end

   assign high_voltage_enable = hve_reg;
   assign erase_suspend = susp_reg;
   assign program_mode = pgm_reg;
   assign erase_mode = ers_reg;

   // ****************************************
   // edges of the high-voltage controls
   // ****************************************
   logic hve_rise;
   logic hve_fall;
   logic susp_rise;
   logic susp_fall;

   dfms_edge u_hve_edge (
      .clock(clock),
      .srst(srst),
      .level(hve_reg),
      .rise(hve_rise),
      .fall(hve_fall)
   );

   dfms_edge u_susp_edge (
      .clock(clock),
      .srst(srst),
      .level(susp_reg),
      .rise(susp_rise),
      .fall(susp_fall)
   );

   // ****************************************
   // high-voltage sequence controller
   // ****************************************
   dfms_state_t state_reg;
   dfms_state_t state_next;
   logic done_reg;
   logic done_next;
   logic suspended_reg;
   logic suspended_next;
   logic dly_load;
   logic [CNT_W-1:0] dly_count;
   logic dly_expire;
   logic seq_load;
   logic seq_expire;
   logic seq_busy;

   // an abort or suspend is a wind-down period; done rises when it expires
   wire op_modify = pgm_reg | ers_reg;
   wire do_resume = susp_fall & suspended_reg & hve_reg;

   always_comb begin
      state_next = state_reg;
      done_next = done_reg;
      suspended_next = suspended_reg;
      dly_load = 1'b0;
      dly_count = CNT_W'(DFMS_ABORT_CYC);
      seq_load = 1'b0;
      case (state_reg)
         DFMS_IDLE: begin
            if ((hve_rise && op_modify) || do_resume) begin
               state_next = DFMS_RUN;
               done_next = 1'b0; // [R6] [R10]
               suspended_next = 1'b0;
               seq_load = ~do_resume | ~seq_busy;
            end
         end
         DFMS_RUN: begin
            if (hve_fall) begin
               state_next = DFMS_STOP; // [R8]
               dly_load = 1'b1;
               suspended_next = 1'b0;
            end else if (susp_rise && ers_reg) begin
               state_next = DFMS_STOP; // [R9]
               dly_load = 1'b1;
               dly_count = CNT_W'(DFMS_SUSP_CYC);
               suspended_next = 1'b1;
            end else if (seq_expire || seq_complete) begin
               state_next = DFMS_IDLE;
               done_next = 1'b1; // [R7] [R10]
            end
         end
         DFMS_STOP: begin
            if (dly_expire) begin
               state_next = DFMS_IDLE;
               done_next = 1'b1; // [R8] [R9] [R10]
            end
         end
         default: begin
            state_next = DFMS_IDLE;
            done_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= DFMS_IDLE;
         done_reg <= DFMS_RST_DONE; // [R5]
         suspended_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_reg <= done_next;
         suspended_reg <= suspended_next;
      end
   end

   // latency timer for abort and suspend
   dfms_delay #(.CNT_W(CNT_W)) u_stop_dly (
      .clock(clock),
      .srst(srst),
      .load(dly_load),
      .count(dly_count),
      .cancel(1'b0),
      .expire(dly_expire),
      .busy()
   );

   // sequence length model; an external completion pulse ends it sooner
   dfms_delay #(.CNT_W(CNT_W)) u_seq_dly (
      .clock(clock),
      .srst(srst),
      .load(seq_load),
      .count(CNT_W'(SEQ_CYCLES)),
      .cancel(hve_fall),
      .expire(seq_expire),
      .busy(seq_busy)
   );

   assign hv_active = ~done_reg;

   // ****************************************
   // access space latch
   // ****************************************
   logic space_reg;

   // held between first interlock writes so a mid-operation change cannot retarget
   always_ff @(posedge clock) begin
      if (srst) begin
         space_reg <= DFMS_RST_SPACE;
      end else if (first_interlock_write) begin
         space_reg <= space_ctl_reg; // [R4]
      end
   end

   assign access_space_select = space_reg; // [R3]

   // ****************************************
   // read-during-modify error flag
   // ****************************************
   logic rww_reg;
   wire modify_busy = (state_reg != DFMS_IDLE) | integrity_check;
   wire rww_event = array_read & modify_busy; // [R1]
   wire rww_clear = cfg_wr & req.wdata[DFMS_BIT_RWW]; // [R11]

   // set wins over a clear in the same cycle; software writes never set it
   always_ff @(posedge clock) begin
      if (srst) begin
         rww_reg <= DFMS_RST_RWW;
      end else if (rww_event) begin
         rww_reg <= 1'b1; // [R1] [R2]
      end else if (rww_clear) begin
         rww_reg <= 1'b0; // [R2] [R11]
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   logic [DFMS_IRQ_W-1:0] irq_sts_reg;
   logic [DFMS_IRQ_W-1:0] irq_msk_reg;
   logic [DFMS_IRQ_W-1:0] irq_evt;
   logic [DFMS_IRQ_W-1:0] irq_clr;

   assign irq_evt[DFMS_IRQ_RWW] = rww_event;
   assign irq_evt[DFMS_IRQ_DONE] = done_next & ~done_reg;
   assign irq_clr = sts_wr ? req.wdata[DFMS_IRQ_W-1:0] : '0;

   always_ff @(posedge clock) begin
      if (srst) begin
         irq_sts_reg <= DFMS_RST_IRQ;
         irq_msk_reg <= DFMS_RST_IRQ;
      end else begin
         irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_evt;
         if (msk_wr) begin
            irq_msk_reg <= req.wdata[DFMS_IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_sts_reg & irq_msk_reg);

   // ****************************************
   // read data
   // ****************************************
   logic [31:0] cfg_view;
   logic [31:0] rd_mux;

   always_comb begin
      cfg_view = 32'h0000_0000;
      cfg_view[DFMS_BIT_HVE] = hve_reg;
      cfg_view[DFMS_BIT_SUSP] = susp_reg;
      cfg_view[DFMS_BIT_ERS] = ers_reg;
      cfg_view[DFMS_BIT_PGM] = pgm_reg;
      cfg_view[DFMS_BIT_DONE] = done_reg; // [R10]
      cfg_view[DFMS_BIT_SPACE] = space_ctl_reg;
      cfg_view[DFMS_BIT_RWW] = rww_reg;
   end

   assign rd_mux = (req.addr == DFMS_ADDR_CONFIG) ? cfg_view :
                   (req.addr == DFMS_ADDR_IRQ_STATUS) ? {30'h0, irq_sts_reg} :
                   (req.addr == DFMS_ADDR_IRQ_MASK) ? {30'h0, irq_msk_reg} :
                   32'h0000_0000;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (req.rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

//--- rtl/dfms_pkg.sv
// package for the data-flash modify status block: register map, field layout, timing
// assumes a single 200 MHz clock domain and a plain strobe register port
package dfms_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] DFMS_ADDR_CONFIG = 8'h00;
   localparam logic [7:0] DFMS_ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] DFMS_ADDR_IRQ_MASK = 8'h08;

   // ****************************************
   // config register fields
   // ****************************************
   localparam int DFMS_BIT_DONE = 10;
   localparam int DFMS_BIT_SPACE = 11;
   localparam int DFMS_BIT_RWW = 15;
   localparam int DFMS_BIT_ERS = 2;
   localparam int DFMS_BIT_SUSP = 1;
   localparam int DFMS_BIT_HVE = 0;
   localparam int DFMS_BIT_PGM = 4;

   // interrupt status bits
   localparam int DFMS_IRQ_RWW = 0;
   localparam int DFMS_IRQ_DONE = 1;
   localparam int DFMS_IRQ_W = 2;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic DFMS_RST_DONE = 1'b1;
   localparam logic DFMS_RST_SPACE = 1'b0;
   localparam logic DFMS_RST_RWW = 1'b0;
   localparam logic [DFMS_IRQ_W-1:0] DFMS_RST_IRQ = 2'h0;

   // ****************************************
   // timing
   // ****************************************
   localparam int DFMS_CLK_PS = 5000;
   localparam int DFMS_ABORT_LAT_NS = 5;
   localparam int DFMS_SUSP_LAT_NS = 5;
   localparam int DFMS_ABORT_CYC = (DFMS_ABORT_LAT_NS * 1000 / DFMS_CLK_PS) < 1 ? 1 :
                                   (DFMS_ABORT_LAT_NS * 1000 / DFMS_CLK_PS);
   localparam int DFMS_SUSP_CYC = (DFMS_SUSP_LAT_NS * 1000 / DFMS_CLK_PS) < 1 ? 1 :
                                  (DFMS_SUSP_LAT_NS * 1000 / DFMS_CLK_PS);
   localparam int DFMS_SEQ_CYC = 64;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dfms_req_t;

   // high-voltage controller states
   typedef enum logic [1:0] {
      DFMS_IDLE = 2'b00,
      DFMS_RUN = 2'b01,
      DFMS_STOP = 2'b10
   } dfms_state_t;

endpackage

//--- rtl/dfms_edge.sv
// rising and falling edge detector for one control level from the same clock domain
// assumes the level is already synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module dfms_edge (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // level in, edges out
   input wire logic level,
   output logic rise,
   output logic fall
);
   logic level_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= level;
      end
   end

   assign rise = level & ~level_reg;
   assign fall = ~level & level_reg;
endmodule
`default_nettype wire

//--- rtl/dfms_delay.sv
// down counter that raises a one-cycle expiry pulse a set number of cycles after a load
// assumes load and cancel come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module dfms_delay #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // control
   input wire logic load,
   input wire logic [CNT_W-1:0] count,
   input wire logic cancel,
   // status
   output logic expire,
   output logic busy
);
   logic [CNT_W-1:0] cnt_reg;
   logic run_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
      end else if (load) begin
         cnt_reg <= count;
         run_reg <= 1'b1;
      end else if (cancel || expire) begin
         run_reg <= 1'b0;
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // expiry when the count reaches one, so a load of n fires n cycles later
   assign expire = run_reg & (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) & ~cancel;
   assign busy = run_reg;
endmodule
`default_nettype wire

//--- testbench/dfms_top_properties.sv
// concurrent checks on the ports of the modify status block
// assumes the single clock domain of dfms_top and its synchronous reset
`timescale 1ns/1ps
`default_nettype none
module dfms_top_checker
   import dfms_pkg::*;
#(
   parameter int SEQ_CYCLES = DFMS_SEQ_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // sequencer side
   input wire logic first_interlock_write,
   input wire logic seq_complete,
   input wire logic high_voltage_enable,
   input wire logic erase_suspend,
   input wire logic program_mode,
   input wire logic erase_mode,
   input wire logic hv_active,
   input wire logic access_space_select,
   input wire logic irq
);
   int run_cnt;
   logic susp_pend;

   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   // ****************************************
   // helper: cycles spent in one high-voltage run
   // ****************************************
   always_ff @(posedge clock) begin
      if (srst || !hv_active) begin
         run_cnt <= 0;
      end else begin
         run_cnt <= run_cnt + 1;
      end
   end

   // helper: an erase was suspended and has not restarted yet, so a suspend
   // release outside a suspension is not taken for a resume
   always_ff @(posedge clock) begin
      if (srst || $rose(hv_active)) begin
         susp_pend <= 1'b0;
      end else if ($rose(erase_suspend) && erase_mode && hv_active && high_voltage_enable) begin
         susp_pend <= 1'b1;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   AST_RESET_IDLE: assert property (disable iff (1'b0) srst |=>
      !hv_active && !irq && reg_rdata == 32'h0000_0000) else $error("reset state wrong");
   AST_DONE_READ: assert property (reg_rd && reg_addr == DFMS_ADDR_CONFIG |=>
      reg_rdata[DFMS_BIT_DONE] != $past(hv_active)) else $error("done bit disagrees");
   AST_START: assert property ($rose(high_voltage_enable) && !hv_active &&
      (program_mode || erase_mode) |=> hv_active) else $error("start not seen");
   AST_NO_MODE: assert property ($rose(high_voltage_enable) && !hv_active &&
      !program_mode && !erase_mode |=> !hv_active [*2]) else $error("start without mode");
   AST_RESUME: assert property ($fell(erase_suspend) && high_voltage_enable &&
      erase_mode && !hv_active && susp_pend |-> ##[1:2] hv_active) else $error("resume not seen");
   AST_ABORT: assert property ($fell(high_voltage_enable) && hv_active |->
      ##[1:3] !hv_active) else $error("abort too slow");
   AST_SUSPEND: assert property ($rose(erase_suspend) && erase_mode && hv_active |->
      ##[1:3] !hv_active) else $error("suspend too slow");
   AST_COMPLETE: assert property (seq_complete && hv_active |-> ##[1:2] !hv_active)
      else $error("completion ignored");
   AST_RUN_BOUND: assert property (run_cnt <= SEQ_CYCLES + 4)
      else $error("run never ends");
   AST_SPACE_HOLD: assert property (!first_interlock_write |=> $stable(access_space_select))
      else $error("space changed without interlock");
endmodule

bind dfms_top dfms_top_checker #(.SEQ_CYCLES(SEQ_CYCLES)) i_checker (
   .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .first_interlock_write(first_interlock_write), .seq_complete(seq_complete),
   .high_voltage_enable(high_voltage_enable), .erase_suspend(erase_suspend),
   .program_mode(program_mode), .erase_mode(erase_mode), .hv_active(hv_active),
   .access_space_select(access_space_select), .irq(irq));
`default_nettype wire

//--- testbench/dfms_top_bench.sv
// self-checking bench for the modify status block
// assumes dfms_top with a shortened sequence count; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module dfms_top_bench
   import dfms_pkg::*;
;
   localparam int SEQ = 16;
   localparam logic [7:0] CFG = DFMS_ADDR_CONFIG;
   logic clock, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic array_read = 1'b0, integrity_check = 1'b0, first_interlock_write = 1'b0;
   logic seq_complete = 1'b0, b;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
   logic high_voltage_enable, erase_suspend, program_mode, erase_mode;
   logic hv_active, access_space_select, irq;
   logic [31:0] seed = 32'hc0a7_861f;
   int errors = 0;
   int checks_done = 0;

   dfms_top #(.SEQ_CYCLES(SEQ)) i_dut (
      .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .array_read(array_read),
      .integrity_check(integrity_check), .first_interlock_write(first_interlock_write),
      .seq_complete(seq_complete), .high_voltage_enable(high_voltage_enable),
      .erase_suspend(erase_suspend), .program_mode(program_mode), .erase_mode(erase_mode),
      .hv_active(hv_active), .access_space_select(access_space_select), .irq(irq));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected config view over the bits this block owns
   function automatic logic [31:0] cfg(logic [31:0] ctl, logic done, logic read_during_modify);
      return (ctl & 32'h0000_0817) | {16'h0000, read_during_modify, 4'h0, done, 10'h000};
   endfunction

   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // sampling lands 1 ns after the edge so its updates are settled
   task automatic step(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic cfg_chk(string name, logic [31:0] ctl, logic done, logic read_during_modify);
      rd(CFG);
      chk(name, d & 32'h0000_8c17, cfg(ctl, done, read_during_modify));
   endtask

   task automatic pulse(int which);
      @(posedge clock);
      case (which)
         0: array_read <= 1'b1;
         1: seq_complete <= 1'b1;
         default: first_interlock_write <= 1'b1;
      endcase
      @(posedge clock);
      {array_read, seq_complete, first_interlock_write} <= 3'b000;
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ****************************************
   // clock, watchdog, sequence
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial begin
      #100000;
      errors++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      cfg_chk("config reset", 0, 1, 0);
      rd(8'hfc);
      chk("unmapped read", d, 0);
      wr(DFMS_ADDR_IRQ_MASK, 32'h0000_0001);
      wr(CFG, 32'h0000_0011);
      step(3);
      cfg_chk("program running", 32'h11, 0, 0);
      chk("hv active", hv_active, 1);
      chk("program outputs", {program_mode, erase_mode, erase_suspend, high_voltage_enable}, 32'h0000_0009);
      pulse(0);
      step(2);
      chk("irq", irq, 1);
      wr(CFG, 32'h0000_0011);
      cfg_chk("flag kept", 32'h11, 0, 1);
      pulse(1);
      step(3);
      cfg_chk("program done", 32'h11, 1, 1);
      rd(DFMS_ADDR_IRQ_STATUS);
      chk("status", d, 32'h0000_0003);
      wr(CFG, 32'h0000_8010);
      wr(DFMS_ADDR_IRQ_STATUS, 32'h0000_0003);
      wr(CFG, 32'h0000_8000);
      step(1);
      chk("irq cleared", irq, 0);
      cfg_chk("flag cleared", 0, 1, 0);
      // masked event: the flag still sets, the interrupt stays low
      wr(DFMS_ADDR_IRQ_MASK, 32'h0000_0000);
      integrity_check <= 1'b1;
      pulse(0);
      integrity_check <= 1'b0;
      step(2);
      chk("irq masked", irq, 0);
      cfg_chk("integrity read", 0, 1, 1);
      wr(CFG, 32'h0000_8000);
      pulse(0);
      cfg_chk("idle read", 0, 1, 0);
      wr(CFG, 32'h0000_0011);
      step(3);
      wr(CFG, 32'h0000_0010);
      step(3);
      cfg_chk("abort", 32'h10, 1, 0);
      chk("hv idle", hv_active, 0);
      wr(CFG, 0);
      wr(CFG, 32'h0000_0005);
      step(3);
      wr(CFG, 32'h0000_0007);
      step(3);
      cfg_chk("suspend", 32'h07, 1, 0);
      chk("erase outputs", {program_mode, erase_mode, erase_suspend, high_voltage_enable}, 32'h0000_0007);
      wr(CFG, 32'h0000_0005);
      step(3);
      cfg_chk("resume", 32'h05, 0, 0);
      step(SEQ + 4);
      cfg_chk("erase end", 32'h05, 1, 0);
      wr(CFG, 32'h0000_0004);
      wr(CFG, 32'h0000_0001);
      step(3);
      cfg_chk("no mode", 32'h01, 1, 0);
      wr(CFG, 0);
      // reset in the middle of a program run must bring done back
      wr(CFG, 32'h0000_0011);
      @(posedge clock);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      cfg_chk("mid reset", 0, 1, 0);
      chk("mid reset hv", hv_active, 0);
      for (int i = 0; i < 6; i++) begin
         d = rnd();
         b = d[0];
         wr(CFG, {20'h0_0000, b, 11'h000});
         if (d[1]) begin
            pulse(2);
         end
         wr(CFG, {20'h0_0000, !b, 11'h000});
         pulse(2);
         wr(CFG, {20'h0_0000, b, 11'h000});
         step(2);
         chk("space", access_space_select, !b);
      end
      stop_test();
   end
endmodule
`default_nettype wire
